// file: hw/hssw_filter.sv
// qualification counter for one current comparator
`timescale 1ns/1ns
module hssw_filter
  #(
    parameter int LIMIT = 320,
    parameter int CNT_W = 11
  )
  (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // comparator condition
    input  wire logic cond_i,
    // one-cycle pulse when the condition has held LIMIT cycles
    output logic      hit_o
  );

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             hit_r;
  logic             hit_nxt;

  // ==========================================================
  // counting
  always_comb
  begin
    cnt_nxt = cnt_r;
    hit_nxt = 1'b0;
    if (!cond_i)
    begin
      cnt_nxt = '0;
    end
    else if (cnt_r < CNT_W'(LIMIT))
    begin
      cnt_nxt = cnt_r + 1'b1;
      hit_nxt = (cnt_r == CNT_W'(LIMIT - 1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= '0;
      hit_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      hit_r <= hit_nxt;
    end
  end

  assign hit_o = hit_r;

endmodule

// file: hw/hssw_pkg.sv
// constants and types shared by the load switch control block
package hssw_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_SW  = 4;
  localparam int NUM_GEN = 2;

  // ==========================================================
  // register indices on the plain register port
  localparam logic [3:0] ADDR_CFG_A  = 4'h0;
  localparam logic [3:0] ADDR_CFG_B  = 4'h1;
  localparam logic [3:0] ADDR_PROT   = 4'h2;
  localparam logic [3:0] ADDR_DUTY_A = 4'h3;
  localparam logic [3:0] ADDR_DUTY_B = 4'h4;
  localparam logic [3:0] ADDR_FREQ   = 4'h5;
  localparam logic [3:0] ADDR_OC     = 4'h6;
  localparam logic [3:0] ADDR_OL     = 4'h7;
  localparam logic [3:0] ADDR_SUPPLY = 4'h8;
  localparam logic [3:0] ADDR_OUTS   = 4'h9;

  // ==========================================================
  // field positions
  localparam int CFG_W       = 3;
  localparam int CFG_STRIDE  = 4;
  localparam int OV_SEL_BIT  = 0;
  localparam int UV_SEL_BIT  = 1;
  localparam int REC_BIT     = 2;
  localparam int SUP_OV_BIT  = 0;
  localparam int SUP_UV_BIT  = 1;

  // ==========================================================
  // per-switch source codes
  localparam logic [2:0] CFG_OFF   = 3'h0;
  localparam logic [2:0] CFG_ON    = 3'h1;
  localparam logic [2:0] CFG_TMR1  = 3'h2;
  localparam logic [2:0] CFG_TMR2  = 3'h3;
  localparam logic [2:0] CFG_PWM_A = 3'h4;
  localparam logic [2:0] CFG_PWM_B = 3'h5;

  // ==========================================================
  // reset values
  localparam logic [2:0] CFG_RST  = 3'h0;
  localparam logic [2:0] PROT_RST = 3'h0;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] FREQ_RST = 2'h0;

  // ==========================================================
  // chip power modes
  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b000,
    MODE_STOP     = 3'b001,
    MODE_SLEEP    = 3'b010,
    MODE_RESTART  = 3'b011,
    MODE_FAILSAFE = 3'b100
  } hssw_mode_t;

  // ==========================================================
  // timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int CLK_MHZ      = CLK_HZ / 1_000_000;
  localparam int OC_FILTER_NS = 16_000;
  localparam int OL_FILTER_NS = 64_000;
  // least times, rounded up to whole cycles
  localparam int OC_FILTER_CYC = (OC_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int OL_FILTER_CYC = (OL_FILTER_NS * CLK_MHZ + 999) / 1000;
  localparam int PWM_STEPS     = 256;
  localparam int PWM_LO_HZ     = 200;
  localparam int PWM_HI_HZ     = 400;
  localparam int PWM_LO_DIV    = CLK_HZ / (PWM_LO_HZ * PWM_STEPS);
  localparam int PWM_HI_DIV    = CLK_HZ / (PWM_HI_HZ * PWM_STEPS);
  localparam int PRESC_W       = 9;

endpackage

// file: hw/hssw_top.sv
// control and protection logic for four load switch outputs
//
// How it works
// - output driven by direct, timer or pulse source
// - configuration writable only in normal mode
// - restart or fail-safe entry forces outputs off
// - supply over-voltage switches outputs off unless deselected
// - supply under-voltage switches outputs off unless deselected
// - without recovery bit, fault end clears configuration
// - supply faults set only their own flags
// - filtered over-current switches that output off
// - over-current sets flag, clears configuration field
// - over-current flags sticky until software clears
// - low current while on sets open-load flag
// - open-load flags held until software clears
// - protection keeps working in stop and sleep
// - software may re-enable after forced off
// - two pulse generators with 8-bit duty
// - each generator selects 200 or 400 Hz
// - each output assignable to any timer/generator
// - pulse output starts as soon as assigned
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module hssw_top
  import hssw_pkg::*;
  (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // register port
    input  wire logic [3:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output logic      [7:0]       reg_rdata_o,
    // chip power mode
    input  wire logic [2:0]       mode_i,
    // switch supply comparators
    input  wire logic             supply_ov_i,
    input  wire logic             supply_uv_i,
    // per-output current comparators
    input  wire logic [NUM_SW-1:0] overcurrent_i,
    input  wire logic [NUM_SW-1:0] open_load_i,
    // internal timers
    input  wire logic             timer1_i,
    input  wire logic             timer2_i,
    // switch drives
    output logic [NUM_SW-1:0]     load_switch_output_o
  );

  // ==========================================================
  // decode helpers
  function automatic logic src_drive(input logic [2:0] cfg, input logic t1,
                                     input logic t2, input logic [1:0] pwm);
    logic d;
    d = 1'b0;
    case (cfg)
      CFG_ON:    d = 1'b1;
      CFG_TMR1:  d = t1;
      CFG_TMR2:  d = t2;
      CFG_PWM_A: d = pwm[0];
      CFG_PWM_B: d = pwm[1];
      default:   d = 1'b0;
    endcase
    return d;
  endfunction

  function automatic logic [3:0] cfg_addr(input int idx);
    return (idx < 2) ? ADDR_CFG_A : ADDR_CFG_B;
  endfunction

  // ==========================================================
  // state
  logic [2:0]        cfg_r   [NUM_SW];
  logic [2:0]        cfg_nxt [NUM_SW];
  logic [2:0]        prot_r;
  logic [2:0]        prot_nxt;
  logic [7:0]        duty_r   [NUM_GEN];
  logic [7:0]        duty_nxt [NUM_GEN];
  logic [1:0]        freq_r;
  logic [1:0]        freq_nxt;
  logic [NUM_SW-1:0] oc_flag_r;
  logic [NUM_SW-1:0] oc_flag_nxt;
  logic [NUM_SW-1:0] ol_flag_r;
  logic [NUM_SW-1:0] ol_flag_nxt;
  logic [1:0]        sup_flag_r;
  logic [1:0]        sup_flag_nxt;
  logic              fault_d_r;
  logic              off_mode_d_r;
  logic [NUM_SW-1:0] sw_r;
  logic [NUM_SW-1:0] sw_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;

  logic              cfg_wr_ok;
  logic              off_mode;
  logic              fault_now;
  logic              clear_all;
  logic [NUM_SW-1:0] oc_evt;
  logic [NUM_SW-1:0] ol_evt;
  logic [NUM_GEN-1:0] pwm_on;

  // ==========================================================
  // mode and supply fault conditions
  always_comb
  begin
    cfg_wr_ok = reg_wr_i && (mode_i == MODE_NORMAL);
    off_mode  = (mode_i == MODE_RESTART) || (mode_i == MODE_FAILSAFE);
    // selection bits set to 1 disable the shutdown
    fault_now = (supply_ov_i && !prot_r[OV_SEL_BIT])
             || (supply_uv_i && !prot_r[UV_SEL_BIT]);
    // configuration is dropped on fault end without recovery, and on forced-off entry
    clear_all = (fault_d_r && !fault_now && !prot_r[REC_BIT])
             || (off_mode && !off_mode_d_r);
  end

  // ==========================================================
  // current filters, qualified only while the switch is on
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SW; gi++)
    begin : g_sense
      hssw_filter #(
        .LIMIT (OC_FILTER_CYC),
        .CNT_W (11)
      ) u_oc (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .cond_i  (overcurrent_i[gi] && sw_r[gi]),
        .hit_o   (oc_evt[gi])
      );
      hssw_filter #(
        .LIMIT (OL_FILTER_CYC),
        .CNT_W (11)
      ) u_ol (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .cond_i  (open_load_i[gi] && sw_r[gi]),
        .hit_o   (ol_evt[gi])
      );
    end
  endgenerate

  // ==========================================================
  // pulse generators, free running so an assignment takes effect at once
  generate
    for (gi = 0; gi < NUM_GEN; gi++)
    begin : g_pwm
      logic [PRESC_W-1:0] presc_r;
      logic [PRESC_W-1:0] presc_nxt;
      logic [7:0]         step_r;
      logic [7:0]         step_nxt;
      logic [PRESC_W-1:0] div_last;

      always_comb
      begin
        div_last  = freq_r[gi] ? PRESC_W'(PWM_HI_DIV - 1)
                               : PRESC_W'(PWM_LO_DIV - 1);
        presc_nxt = presc_r + 1'b1;
        step_nxt  = step_r;
        // >= covers a rate change that leaves the prescaler past the new end
        if (presc_r >= div_last)
        begin
          presc_nxt = '0;
          step_nxt  = step_r + 1'b1;
        end
      end

      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          presc_r <= '0;
          step_r  <= '0;
        end
        else
        begin
          presc_r <= presc_nxt;
          step_r  <= step_nxt;
        end
      end

      assign pwm_on[gi] = (step_r < duty_r[gi]);
    end
  endgenerate

  // ==========================================================
  // configuration, status flags and drives
  always_comb
  begin
    prot_nxt = prot_r;
    freq_nxt = freq_r;
    for (int g = 0; g < NUM_GEN; g++)
    begin
      duty_nxt[g] = duty_r[g];
    end
    if (cfg_wr_ok)
    begin
      if (reg_addr_i == ADDR_PROT)
      begin
        prot_nxt = reg_wdata_i[2:0];
      end
      else if (reg_addr_i == ADDR_DUTY_A)
      begin
        duty_nxt[0] = reg_wdata_i;
      end
      else if (reg_addr_i == ADDR_DUTY_B)
      begin
        duty_nxt[1] = reg_wdata_i;
      end
      else if (reg_addr_i == ADDR_FREQ)
      begin
        freq_nxt = reg_wdata_i[1:0];
      end
    end

    for (int i = 0; i < NUM_SW; i++)
    begin
      cfg_nxt[i] = cfg_r[i];
      if (cfg_wr_ok && reg_addr_i == cfg_addr(i))
      begin
        cfg_nxt[i] = reg_wdata_i[(i % 2) * CFG_STRIDE +: CFG_W];
      end
      // hardware clears win over a same-cycle write
      if (clear_all || oc_evt[i])
      begin
        cfg_nxt[i] = CFG_OFF;
      end
      sw_nxt[i] = src_drive(cfg_nxt[i], timer1_i, timer2_i, pwm_on)
                && !fault_now && !off_mode;
    end

    // write-one-to-clear in any mode; a same-cycle event keeps the flag set
    oc_flag_nxt  = oc_flag_r | oc_evt;
    ol_flag_nxt  = ol_flag_r | ol_evt;
    sup_flag_nxt = sup_flag_r | {supply_uv_i, supply_ov_i};
    if (reg_wr_i && reg_addr_i == ADDR_OC)
    begin
      oc_flag_nxt = (oc_flag_r & ~reg_wdata_i[NUM_SW-1:0]) | oc_evt;
    end
    else if (reg_wr_i && reg_addr_i == ADDR_OL)
    begin
      ol_flag_nxt = (ol_flag_r & ~reg_wdata_i[NUM_SW-1:0]) | ol_evt;
    end
    else if (reg_wr_i && reg_addr_i == ADDR_SUPPLY)
    begin
      sup_flag_nxt = (sup_flag_r & ~reg_wdata_i[1:0]) | {supply_uv_i, supply_ov_i};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < NUM_SW; i++)
      begin
        cfg_r[i] <= CFG_RST;
      end
      for (int g = 0; g < NUM_GEN; g++)
      begin
        duty_r[g] <= DUTY_RST;
      end
      prot_r       <= PROT_RST;
      freq_r       <= FREQ_RST;
      oc_flag_r    <= '0;
      ol_flag_r    <= '0;
      sup_flag_r   <= '0;
      fault_d_r    <= 1'b0;
      off_mode_d_r <= 1'b0;
      sw_r         <= '0;
    end
    else
    begin
      cfg_r        <= cfg_nxt;
      duty_r       <= duty_nxt;
      prot_r       <= prot_nxt;
      freq_r       <= freq_nxt;
      oc_flag_r    <= oc_flag_nxt;
      ol_flag_r    <= ol_flag_nxt;
      sup_flag_r   <= sup_flag_nxt;
      fault_d_r    <= fault_now;
      off_mode_d_r <= off_mode;
      sw_r         <= sw_nxt;
    end
  end

  assign load_switch_output_o = sw_r;

  // ==========================================================
  // read port: data stands only in the cycle after the strobe
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (!reg_rd_i)
    begin
      rdata_nxt = 8'h00;
    end
    else if (reg_addr_i == ADDR_CFG_A)
    begin
      rdata_nxt = {1'b0, cfg_r[1], 1'b0, cfg_r[0]};
    end
    else if (reg_addr_i == ADDR_CFG_B)
    begin
      rdata_nxt = {1'b0, cfg_r[3], 1'b0, cfg_r[2]};
    end
    else if (reg_addr_i == ADDR_PROT)
    begin
      rdata_nxt = {5'h00, prot_r};
    end
    else if (reg_addr_i == ADDR_DUTY_A)
    begin
      rdata_nxt = duty_r[0];
    end
    else if (reg_addr_i == ADDR_DUTY_B)
    begin
      rdata_nxt = duty_r[1];
    end
    else if (reg_addr_i == ADDR_FREQ)
    begin
      rdata_nxt = {6'h00, freq_r};
    end
    else if (reg_addr_i == ADDR_OC)
    begin
      rdata_nxt = {4'h0, oc_flag_r};
    end
    else if (reg_addr_i == ADDR_OL)
    begin
      rdata_nxt = {4'h0, ol_flag_r};
    end
    else if (reg_addr_i == ADDR_SUPPLY)
    begin
      rdata_nxt = {4'h0, supply_uv_i, supply_ov_i, sup_flag_r};
    end
    else if (reg_addr_i == ADDR_OUTS)
    begin
      rdata_nxt = {4'h0, sw_r};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;

endmodule

// file: tb/hssw_load_model.sv
// behavioural loads on the four switch outputs
`timescale 1ns/1ns
module hssw_load_model
  (
    // switch drives
    input  wire logic [3:0] drive_i,
    // faults commanded by the bench
    input  wire logic [3:0] short_i,
    input  wire logic [3:0] open_i,
    // current comparators
    output logic      [3:0] overcurrent_o,
    output logic      [3:0] open_load_o
  );
  // an off switch carries no current, so its open-load comparator reads high
  assign overcurrent_o = drive_i & short_i;
  assign open_load_o   = ~drive_i | open_i;
endmodule

// file: tb/hssw_top_asserts.sv
// assertion checker for the load switch control block
`timescale 1ns/1ns
module hssw_checker
  import hssw_pkg::*;
  (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // mode, comparators and timers
    input wire logic [2:0] mode_i,
    input wire logic       supply_ov_i,
    input wire logic       supply_uv_i,
    input wire logic [3:0] overcurrent_i,
    input wire logic [3:0] open_load_i,
    input wire logic       timer1_i,
    input wire logic       timer2_i,
    // switch drives
    input wire logic [3:0] load_switch_output_o
  );
  // ==========
  // shadow of the protection selects and a count of cycles on into a short
  logic [2:0] prot_r;
  logic [2:0] prot_nxt;
  logic [9:0] oc_cnt_r;
  logic [9:0] oc_cnt_nxt;

  always_comb
  begin
    prot_nxt = prot_r;
    if (reg_wr_i && reg_addr_i == ADDR_PROT && mode_i == MODE_NORMAL)
      prot_nxt = reg_wdata_i[2:0];
    oc_cnt_nxt = (overcurrent_i[0] && load_switch_output_o[0]) ? oc_cnt_r + 10'h001 : 10'h000;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prot_r   <= 3'h0;
      oc_cnt_r <= 10'h000;
    end
    else
    begin
      prot_r   <= prot_nxt;
      oc_cnt_r <= oc_cnt_nxt;
    end
  end

  // ==========
  // properties
  default clocking cb_d @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  forced_off_a:
    assert property ((mode_i == MODE_RESTART || mode_i == MODE_FAILSAFE) |=> load_switch_output_o == 4'h0)
    else $error("output on in restart or fail-safe");
  ov_off_a:
    assert property ((supply_ov_i && !prot_r[OV_SEL_BIT]) |=> load_switch_output_o == 4'h0)
    else $error("output on during supply over-voltage");
  uv_off_a:
    assert property ((supply_uv_i && !prot_r[UV_SEL_BIT]) |=> load_switch_output_o == 4'h0)
    else $error("output on during supply under-voltage");
  oc_limit_a:
    assert property (oc_cnt_r < 10'h148)
    else $error("shorted output not switched off");
  rd_idle_a:
    assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data without a read");
  outs_read_a:
    assert property ((reg_rd_i && reg_addr_i == ADDR_OUTS) |=> reg_rdata_o == {4'h0, $past(load_switch_output_o)})
    else $error("drive state read wrong");
  sup_flag_a:
    assert property (supply_ov_i ##1 (supply_ov_i && reg_rd_i && reg_addr_i == ADDR_SUPPLY) |=> reg_rdata_o[SUP_OV_BIT])
    else $error("over-voltage flag missing");
  unmapped_a:
    assert property ((reg_rd_i && reg_addr_i > ADDR_OUTS) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind hssw_top hssw_checker chk (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .mode_i, .supply_ov_i, .supply_uv_i, .overcurrent_i, .open_load_i, .timer1_i, .timer2_i, .load_switch_output_o);

// file: tb/hssw_top_bench.sv
// self-checking bench for the load switch control block
`timescale 1ns/1ns
module hssw_top_bench
  import hssw_pkg::*;
  ;
  logic       clk_i   = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [3:0] addr    = 4'h0;
  logic [7:0] wdata   = 8'h00;
  logic       wr      = 1'b0;
  logic       rd      = 1'b0;
  logic [7:0] rdata;
  logic [2:0] mode    = MODE_NORMAL;
  logic       ov      = 1'b0;
  logic       uv      = 1'b0;
  logic       t1      = 1'b0;
  logic       t2      = 1'b0;
  logic [3:0] short_c = 4'h0;
  logic [3:0] open_c  = 4'h0;
  logic [3:0] oc;
  logic [3:0] ol;
  logic [3:0] outs;
  int         fails   = 0;
  int         n_tests = 0;
  int         cycles  = 0;

  always #25 clk_i = ~clk_i;

  hssw_top dut (.clk_i, .rst_n_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .mode_i(mode), .supply_ov_i(ov), .supply_uv_i(uv), .overcurrent_i(oc),
    .open_load_i(ol), .timer1_i(t1), .timer2_i(t2), .load_switch_output_o(outs));
  hssw_load_model loads (.drive_i(outs), .short_i(short_c), .open_i(open_c), .overcurrent_o(oc), .open_load_o(ol));

  // ==========
  // shared tasks
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1 chk({24'h0, rdata}, {24'h0, e});
    @(posedge clk_i);
  endtask

  // drive state is checked n edges on, then the task returns on an edge
  task automatic see(input int n, input logic [3:0] e);
    repeat (n) @(posedge clk_i);
    #1 chk({28'h0, outs}, {28'h0, e});
    @(posedge clk_i);
  endtask

  // ==========
  // scenarios
  task automatic t_source;
    for (int a = 0; a < 16; a++)
      rd_reg(a[3:0], 8'h00);
    wr_reg(ADDR_CFG_A, 8'h21);
    wr_reg(ADDR_CFG_B, 8'h30);
    t1 <= 1'b1;
    see(2, 4'h3);
    t1 <= 1'b0;
    t2 <= 1'b1;
    see(2, 4'h9);
    mode <= MODE_STOP;
    wr_reg(ADDR_CFG_A, 8'h00);
    see(1, 4'h9);
    rd_reg(ADDR_CFG_A, 8'h21);
    mode <= MODE_FAILSAFE;
    see(2, 4'h0);
    mode <= MODE_RESTART;
    see(2, 4'h0);
    mode <= MODE_NORMAL;
    wr_reg(ADDR_CFG_B, 8'h00);
    wr_reg(ADDR_CFG_A, 8'h11);
    see(1, 4'h3);
    $display("source and mode test done");
  endtask

  task automatic t_supply;
    ov <= 1'b1;
    see(2, 4'h0);
    rd_reg(ADDR_SUPPLY, 8'h05);
    rd_reg(ADDR_OC, 8'h00);
    rd_reg(ADDR_OL, 8'h00);
    ov <= 1'b0;
    see(2, 4'h0);
    rd_reg(ADDR_CFG_A, 8'h00);
    wr_reg(ADDR_SUPPLY, 8'h03);
    rd_reg(ADDR_SUPPLY, 8'h00);
    wr_reg(ADDR_PROT, 8'h04);
    wr_reg(ADDR_CFG_A, 8'h11);
    uv <= 1'b1;
    see(2, 4'h0);
    uv <= 1'b0;
    see(2, 4'h3);
    wr_reg(ADDR_PROT, 8'h07);
    ov <= 1'b1;
    see(3, 4'h3);
    ov <= 1'b0;
    uv <= 1'b1;
    see(3, 4'h3);
    uv <= 1'b0;
    wr_reg(ADDR_SUPPLY, 8'h03);
    $display("supply test done");
  endtask

  task automatic t_oc;
    int n;
    short_c[0] <= 1'b1;
    repeat (300) @(posedge clk_i);
    short_c[0] <= 1'b0;
    see(2, 4'h3);
    short_c[0] <= 1'b1;
    n = 0;
    while (outs[0] === 1'b1 && n < 400)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    @(posedge clk_i);
    short_c[0] <= 1'b0;
    chk({31'h0, n > 318 && n < 326}, 32'h1);
    rd_reg(ADDR_CFG_A, 8'h10);
    rd_reg(ADDR_OC, 8'h01);
    wr_reg(ADDR_OC, 8'h01);
    rd_reg(ADDR_OC, 8'h00);
    t1 <= 1'b1;
    wr_reg(ADDR_CFG_A, 8'h12);
    see(1, 4'h3);
    $display("over-current test done");
  endtask

  task automatic t_ol;
    mode      <= MODE_STOP;
    open_c[1] <= 1'b1;
    see(1400, 4'h3);
    rd_reg(ADDR_OL, 8'h02);
    open_c[1] <= 1'b0;
    rd_reg(ADDR_OL, 8'h02);
    wr_reg(ADDR_OL, 8'h02);
    rd_reg(ADDR_OL, 8'h00);
    mode <= MODE_NORMAL;
    $display("open-load test done");
  endtask

  // one full slow period holds exactly two fast periods
  task automatic t_pwm;
    int na;
    int nb;
    wr_reg(ADDR_DUTY_A, 8'hFF);
    wr_reg(ADDR_DUTY_B, 8'hC0);
    wr_reg(ADDR_FREQ, 8'h02);
    wr_reg(ADDR_CFG_B, 8'h54);
    mode <= MODE_SLEEP;
    na = 0;
    nb = 0;
    repeat (PWM_STEPS * PWM_LO_DIV)
    begin
      @(posedge clk_i);
      #1 na += int'(outs[2]);
      nb += int'(outs[3]);
    end
    chk(na, (PWM_STEPS - 1) * PWM_LO_DIV);
    chk(nb, 2 * 8'hC0 * PWM_HI_DIV);
    $display("pulse test done");
  endtask

  // ==========
  // run control
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 120000)
    begin
      fails++;
      finish_test;
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_source;
    t_supply;
    t_oc;
    t_ol;
    t_pwm;
    finish_test;
  end
endmodule
